// ---- hdl/drm_mode_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// [RULE1] mode codes: freerun, holdover, forced, automatic
// [RULE2] automatic picks by availability and priority
// [RULE3] automatic holds only when both references fail
// [RULE4] forced mode locks to selected reference only
// [RULE5] forced reference failure holds, never switches
// [RULE6] forced holdover ignores references, keeps last
// [RULE7] freerun runs from crystal oscillator only
// [RULE8] feedback enable applies external feedback phase
// [RULE9] feedback disabled ignores external feedback phase
// [RULE10] single feedback path used whatever loop
// [RULE11] automatic mode reads selected reference index
// [RULE12] forced mode bits 7:6 choose reference
// [RULE13] freerun and holdover ignore selection bits
// [RULE14] holdover mask zero blocks holdover entry
// [RULE15] holdover mask order: loss, cycle, coarse, guard
// [RULE16] software avoids guard-only holdover mask setting
// [RULE17] switch mask zero blocks reference switching; code still reverts to a usable higher priority reference
// [RULE18] switch mask uses same failure order
// [RULE19] sticky bit 0 set during holdover
// [RULE20] sticky bit 1 set while locked
// [RULE21] automatic reverts to higher priority reference
// [RULE22] equal priority references never revert
// [RULE23] sticky flags held until status read
module drm_mode_ctrl #(
  parameter int PHASE_W = 16
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [7:0]           reg_rdata_o,
  input  wire drm_pkg::drm_fail_t   ref0_fail_i,
  input  wire drm_pkg::drm_fail_t   ref1_fail_i,
  input  wire drm_pkg::drm_prio_t   ref0_prio_i,
  input  wire drm_pkg::drm_prio_t   ref1_prio_i,
  input  wire logic                 loop_locked_i,
  input  wire logic [PHASE_W-1:0]   ext_fb_phase_i,
  output drm_pkg::drm_loop_e        loop_state_o,
  output logic                      active_ref_o,
  output logic                      use_crystal_o,
  output logic                      feedback_compensation_enable_o,
  output logic      [PHASE_W-1:0]   fb_phase_o
);
  import drm_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    drm_loop_e          loop;
    drm_mode_t          mode;
    logic [1:0]         refsel_ctl;
    logic               fb_en;
    drm_fail_t          hold_mask;
    drm_fail_t          sw_mask;
    logic [1:0]         sticky;
    logic               active_ref;
    logic               use_xtal;
    logic [7:0]         rdata;
    logic [PHASE_W-1:0] fb_phase;
  } drm_ctrl_s;

  drm_ctrl_s cur_r;
  drm_ctrl_s cur_nxt;
  drm_sel_if sif ();

  logic      forced_ref;
  logic      forced_fail;
  logic      sticky_clr;
  logic [1:0] sticky_set;

  // ****************************************************************
  // automatic reference picker
  // ****************************************************************
  assign sif.auto_mode = (cur_r.mode == MODE_AUTO);
  assign sif.cur_ref   = cur_r.active_ref;
  assign sif.fail0     = ref0_fail_i;
  assign sif.fail1     = ref1_fail_i;
  assign sif.prio0     = ref0_prio_i;
  assign sif.prio1     = ref1_prio_i;
  assign sif.hold_mask = cur_r.hold_mask;
  assign sif.sw_mask   = cur_r.sw_mask;

  drm_ref_sel u_ref_sel (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .sif       (sif)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    cur_nxt     = cur_r;
    forced_ref  = cur_r.refsel_ctl[0];
    forced_fail = fail_hit(forced_ref ? ref1_fail_i : ref0_fail_i,
                           cur_r.hold_mask); // RULE14 RULE15
    sticky_clr  = reg_rd_i && (reg_addr_i == ADDR_STICKY);
    sticky_set  = 2'h0;

    // register writes; reserved bits are not kept and read zero
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_MODE_REFSEL: begin
          cur_nxt.mode       = reg_wdata_i[MODE_LSB +: 2];
          cur_nxt.fb_en      = reg_wdata_i[FB_EN_BIT];
          cur_nxt.refsel_ctl = reg_wdata_i[REFSEL_LSB +: 2]; // RULE12
        end
        ADDR_FAIL_MASK: begin
          cur_nxt.hold_mask = reg_wdata_i[HOLD_MASK_LSB +: 4]; // RULE14
          cur_nxt.sw_mask   = reg_wdata_i[SW_MASK_LSB +: 4]; // RULE17
        end
        default: begin
        end
      endcase
    end

    // loop mode follows the mode field seen last cycle
    case (cur_r.mode)
      MODE_FREERUN: begin
        cur_nxt.loop = LOOP_FREERUN; // RULE1 RULE7 RULE13
      end
      MODE_HOLDOVER: begin
        // active reference kept: holdover uses the last one
        cur_nxt.loop = LOOP_HOLDOVER; // RULE1 RULE6 RULE13
      end
      MODE_FORCED: begin
        cur_nxt.active_ref = forced_ref; // RULE4
        cur_nxt.loop = forced_fail ? LOOP_HOLDOVER
                                   : LOOP_LOCKED; // RULE5
      end
      default: begin
        cur_nxt.active_ref = sif.sel; // RULE2
        cur_nxt.loop = sif.hold ? LOOP_HOLDOVER
                                : LOOP_LOCKED; // RULE3
      end
    endcase
    cur_nxt.use_xtal = (cur_nxt.loop == LOOP_FREERUN); // RULE7

    // sticky flags; a set in the read cycle survives the clear
    sticky_set[STICKY_HOLD_BIT] = (cur_r.loop == LOOP_HOLDOVER); // RULE19
    sticky_set[STICKY_LOCK_BIT] = (cur_r.loop == LOOP_LOCKED)
                                  && loop_locked_i; // RULE20
    cur_nxt.sticky = sticky_set
                   | (sticky_clr ? 2'h0 : cur_r.sticky); // RULE23

    // read data, one cycle after the strobe
    cur_nxt.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_MODE_REFSEL: begin
          cur_nxt.rdata[MODE_LSB +: 2]  = cur_r.mode;
          cur_nxt.rdata[FB_EN_BIT]      = cur_r.fb_en;
          cur_nxt.rdata[REFSEL_LSB +: 2] =
            (cur_r.mode == MODE_AUTO) ? {1'b0, cur_r.active_ref}
                                      : cur_r.refsel_ctl; // RULE11
        end
        ADDR_FAIL_MASK: begin
          cur_nxt.rdata = {cur_r.sw_mask, cur_r.hold_mask};
        end
        ADDR_STICKY: begin
          cur_nxt.rdata[1:0] = cur_r.sticky;
        end
        default: begin
        end
      endcase
    end

    // one feedback input, applied whichever loop made it
    cur_nxt.fb_phase = cur_r.fb_en ? ext_fb_phase_i
                                   : '0; // RULE8 RULE9 RULE10
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cur_r            <= '0;
      cur_r.loop       <= LOOP_FREERUN;
      cur_r.mode       <= RST_MODE_REFSEL[MODE_LSB +: 2];
      cur_r.fb_en      <= RST_MODE_REFSEL[FB_EN_BIT];
      cur_r.refsel_ctl <= RST_MODE_REFSEL[REFSEL_LSB +: 2];
      cur_r.hold_mask  <= RST_FAIL_MASK[HOLD_MASK_LSB +: 4];
      cur_r.sw_mask    <= RST_FAIL_MASK[SW_MASK_LSB +: 4];
      cur_r.sticky     <= RST_STICKY[1:0];
      cur_r.use_xtal   <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign reg_rdata_o                    = cur_r.rdata;
  assign loop_state_o                   = cur_r.loop;
  assign active_ref_o                   = cur_r.active_ref;
  assign use_crystal_o                  = cur_r.use_xtal;
  assign feedback_compensation_enable_o = cur_r.fb_en; // RULE8
  assign fb_phase_o                     = cur_r.fb_phase;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_freerun_xtal: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_FREERUN |=> cur_r.loop == LOOP_FREERUN && cur_r.use_xtal)
    else $error("freerun mode not on crystal"); // RULE1 RULE7

  chk_forced_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_HOLDOVER
    |=> cur_r.loop == LOOP_HOLDOVER && $stable(cur_r.active_ref))
    else $error("forced holdover moved reference"); // RULE6 RULE13

  chk_forced_ref: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_FORCED
    |=> cur_r.active_ref == $past(cur_r.refsel_ctl[0]))
    else $error("forced mode on wrong reference"); // RULE4 RULE12

  chk_forced_fail: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_FORCED && forced_fail
    |=> cur_r.loop == LOOP_HOLDOVER
        && cur_r.active_ref == $past(forced_ref))
    else $error("forced failure did not hold"); // RULE5

  chk_hold_masked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_FORCED && !forced_fail |=> cur_r.loop == LOOP_LOCKED)
    else $error("masked failure caused holdover"); // RULE14 RULE15

  chk_auto_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_AUTO
    |=> cur_r.active_ref == $past(sif.sel)
        && (cur_r.loop == LOOP_HOLDOVER) == $past(sif.hold))
    else $error("automatic mode ignored picker"); // RULE2 RULE3

  chk_fb_enabled: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.fb_en |=> fb_phase_o == $past(ext_fb_phase_i))
    else $error("feedback phase not applied"); // RULE8 RULE10

  chk_fb_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !cur_r.fb_en |=> fb_phase_o == '0)
    else $error("feedback phase used while off"); // RULE9

  chk_sticky_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.loop == LOOP_HOLDOVER |=> cur_r.sticky[STICKY_HOLD_BIT])
    else $error("holdover flag not set"); // RULE19

  chk_sticky_lock: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.loop == LOOP_LOCKED && loop_locked_i
    |=> cur_r.sticky[STICKY_LOCK_BIT])
    else $error("lock flag not set"); // RULE20

  chk_sticky_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !$past(sticky_clr)
    |-> (cur_r.sticky & $past(cur_r.sticky)) == $past(cur_r.sticky))
    else $error("sticky flag lost without read"); // RULE23

  chk_readback_auto: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == ADDR_MODE_REFSEL && cur_r.mode == MODE_AUTO
    |=> reg_rdata_o[REFSEL_LSB +: 2] == {1'b0, $past(cur_r.active_ref)})
    else $error("selected reference status wrong"); // RULE11

  cov_auto_hold: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_AUTO && cur_r.loop == LOOP_HOLDOVER);
  cov_auto_switch: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_AUTO ##1 $changed(cur_r.active_ref));
  cov_forced_lock: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_r.mode == MODE_FORCED && cur_r.loop == LOOP_LOCKED);
  cov_sticky_read: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    sticky_clr && (|cur_r.sticky));

endmodule : drm_mode_ctrl

// ---- hdl/drm_pkg.sv ----
package drm_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_MODE_REFSEL = 8'h33;
  localparam logic [7:0] ADDR_FAIL_MASK   = 8'h34;
  localparam logic [7:0] ADDR_STICKY      = 8'h44;

  localparam logic [7:0] RST_MODE_REFSEL  = 8'h03;
  localparam logic [7:0] RST_FAIL_MASK    = 8'h87;
  localparam logic [7:0] RST_STICKY       = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MODE_LSB        = 0;
  localparam int FB_EN_BIT       = 5;
  localparam int REFSEL_LSB      = 6;
  localparam int HOLD_MASK_LSB   = 0;
  localparam int SW_MASK_LSB     = 4;
  localparam int STICKY_HOLD_BIT = 0;
  localparam int STICKY_LOCK_BIT = 1;

  // failure vector bit order, shared by both masks
  localparam int FAIL_SIGNAL_LOSS  = 0;
  localparam int FAIL_SINGLE_CYCLE = 1;
  localparam int FAIL_COARSE_FREQ  = 2;
  localparam int FAIL_GUARD_TIMER  = 3;

  // ****************************************************************
  // types and codes
  // ****************************************************************
  typedef logic [1:0] drm_mode_t;
  typedef logic [3:0] drm_fail_t;
  typedef logic [2:0] drm_prio_t;

  localparam drm_mode_t MODE_FREERUN  = 2'h0;
  localparam drm_mode_t MODE_HOLDOVER = 2'h1;
  localparam drm_mode_t MODE_FORCED   = 2'h2;
  localparam drm_mode_t MODE_AUTO     = 2'h3;

  localparam drm_prio_t PRIO_DISABLED = 3'h7;

  typedef enum logic [1:0] {
    LOOP_FREERUN,
    LOOP_HOLDOVER,
    LOOP_LOCKED
  } drm_loop_e;

  // a failure counts only where its mask bit is one
  function automatic logic fail_hit(input drm_fail_t fail,
                                    input drm_fail_t mask);
    fail_hit = |(fail & mask);
  endfunction : fail_hit

endpackage : drm_pkg

// ---- hdl/drm_sel_if.sv ----
`timescale 1ns/1ps
interface drm_sel_if;
  import drm_pkg::*;

  logic      auto_mode;
  logic      cur_ref;
  drm_fail_t fail0;
  drm_fail_t fail1;
  drm_prio_t prio0;
  drm_prio_t prio1;
  drm_fail_t hold_mask;
  drm_fail_t sw_mask;
  logic      sel;
  logic      hold;

  modport owner (
    output auto_mode, cur_ref, fail0, fail1, prio0, prio1,
    output hold_mask, sw_mask,
    input  sel, hold
  );
  modport picker (
    input  auto_mode, cur_ref, fail0, fail1, prio0, prio1,
    input  hold_mask, sw_mask,
    output sel, hold
  );
endinterface : drm_sel_if

// ---- hdl/drm_ref_sel.sv ----
`timescale 1ns/1ps
module drm_ref_sel (
  input  wire logic  ref_clk_i,
  input  wire logic  rst_i,
  drm_sel_if.picker  sif
);
  import drm_pkg::*;

  typedef struct packed {
    logic sel;
    logic hold;
  } drm_pick_s;

  drm_pick_s cur_r;
  drm_pick_s cur_nxt;
  drm_fail_t fcur;
  drm_fail_t foth;
  drm_prio_t pcur;
  drm_prio_t poth;
  logic      oth_ok;
  logic      cur_sw;
  logic      cur_hold;
  logic      better;

  always_comb begin
    fcur     = cur_r.sel ? sif.fail1 : sif.fail0;
    foth     = cur_r.sel ? sif.fail0 : sif.fail1;
    pcur     = cur_r.sel ? sif.prio1 : sif.prio0;
    poth     = cur_r.sel ? sif.prio0 : sif.prio1;
    oth_ok   = (poth != PRIO_DISABLED) && !fail_hit(foth, sif.sw_mask);
    cur_sw   = (pcur == PRIO_DISABLED) || fail_hit(fcur, sif.sw_mask);
    cur_hold = (pcur == PRIO_DISABLED) || fail_hit(fcur, sif.hold_mask);
    better   = poth < pcur;
    cur_nxt  = cur_r;
    if (!sif.auto_mode) begin
      // follow the loop so a return to automatic starts from there
      cur_nxt.sel  = sif.cur_ref;
      cur_nxt.hold = 1'b0;
    end else if (oth_ok && (cur_sw || better)) begin
      // strict compare: equal priority never reverts
      cur_nxt.sel  = ~cur_r.sel; // RULE2 RULE21 RULE22
      cur_nxt.hold = 1'b0;
    end else begin
      // a usable other reference keeps the loop out of holdover
      cur_nxt.hold = cur_hold && !oth_ok; // RULE3
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign sif.sel  = cur_r.sel;
  assign sif.hold = cur_r.hold;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_revert_higher: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sif.auto_mode && oth_ok && better |=> cur_r.sel != $past(cur_r.sel))
    else $error("no revert to higher priority reference"); // RULE21
  chk_switch_masked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sif.auto_mode && !cur_sw && !better |=> $stable(cur_r.sel))
    else $error("switch without unmasked failure"); // RULE17 RULE18 RULE22
  chk_auto_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sif.auto_mode && oth_ok |=> !cur_r.hold)
    else $error("holdover while other reference usable"); // RULE3

endmodule : drm_ref_sel

// ---- sim/drm_mode_ctrl_test.sv ----
`timescale 1ns/1ps
module drm_mode_ctrl_test;
  import drm_pkg::*;

  typedef struct {
    int          kind;
    logic [15:0] val;
  } drm_note_s;

  logic              ref_clk_i;
  logic              rst_i;
  logic [7:0]        reg_addr_i;
  logic [7:0]        reg_wdata_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [7:0]        reg_rdata_o;
  drm_fail_t         ref0_fail_i;
  drm_fail_t         ref1_fail_i;
  drm_prio_t         ref0_prio_i;
  drm_prio_t         ref1_prio_i;
  logic              loop_locked_i;
  logic [15:0]       ext_fb_phase_i;
  drm_loop_e         loop_state_o;
  logic              active_ref_o;
  logic              use_crystal_o;
  logic              fb_en_o;
  logic [15:0]       fb_phase_o;
  int                err_total;
  int                cmp_count;
  int                probe_kind;
  int                probe_seen;
  logic              rd_seen;
  logic [31:0]       rnd_r;
  drm_note_s         note_q[$];
  drm_note_s         note;
  logic [7:0]        mw[4];
  drm_loop_e         ms[4];

  drm_mode_ctrl #(.PHASE_W(16)) u_drm_mode_ctrl (
    .ref_clk_i                      (ref_clk_i),
    .rst_i                          (rst_i),
    .reg_addr_i                     (reg_addr_i),
    .reg_wdata_i                    (reg_wdata_i),
    .reg_wr_i                       (reg_wr_i),
    .reg_rd_i                       (reg_rd_i),
    .reg_rdata_o                    (reg_rdata_o),
    .ref0_fail_i                    (ref0_fail_i),
    .ref1_fail_i                    (ref1_fail_i),
    .ref0_prio_i                    (ref0_prio_i),
    .ref1_prio_i                    (ref1_prio_i),
    .loop_locked_i                  (loop_locked_i),
    .ext_fb_phase_i                 (ext_fb_phase_i),
    .loop_state_o                   (loop_state_o),
    .active_ref_o                   (active_ref_o),
    .use_crystal_o                  (use_crystal_o),
    .feedback_compensation_enable_o (fb_en_o),
    .fb_phase_o                     (fb_phase_o)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift

  function automatic logic [15:0] lp(input drm_loop_e s, input logic x,
                                     input logic f);
    lp = {12'h000, s, x, f};
  endfunction : lp

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    note_q.push_back('{0, {8'h00, exp}});
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
  endtask : rd

  task automatic probe(input int k, input logic [15:0] exp);
    @(posedge ref_clk_i);
    note_q.push_back('{k, exp});
    probe_kind <= k;
    @(posedge ref_clk_i);
    probe_kind <= 0;
  endtask : probe

  // auto path needs two cycles; four leaves margin for the register write
  task automatic step(input drm_fail_t f0, input drm_fail_t f1);
    @(posedge ref_clk_i);
    ref0_fail_i <= f0;
    ref1_fail_i <= f1;
    repeat (4) @(posedge ref_clk_i);
  endtask : step

  // ****************************************************************
  // monitor: one note is consumed per result that shows up
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    if (rd_seen || probe_seen != 0) begin
      if (note_q.size() == 0) begin
        err_total++;
        $display("BAD note queue expected entry seen empty");
      end else begin
        note = note_q.pop_front();
        case (note.kind)
          0: check("read data", {8'h00, reg_rdata_o}, note.val);
          1: check("loop", lp(loop_state_o, use_crystal_o, fb_en_o),
                   note.val);
          2: check("fb phase", fb_phase_o, note.val);
          default: check("active ref", {15'h0000, active_ref_o}, note.val);
        endcase
      end
    end
    rd_seen    = reg_rd_i;
    probe_seen = probe_kind;
  end

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_total++;
    print_verdict();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_i = 1'b1; reg_addr_i = 8'h00; reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0; reg_rd_i = 1'b0; ref0_fail_i = 4'h0;
    ref1_fail_i = 4'h0; ref0_prio_i = 3'h0; ref1_prio_i = 3'h1;
    loop_locked_i = 1'b1; ext_fb_phase_i = 16'h0000;
    err_total = 0; cmp_count = 0; probe_kind = 0; probe_seen = 0;
    rd_seen = 1'b0; rnd_r = 32'h0000_0026;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rd(ADDR_MODE_REFSEL, RST_MODE_REFSEL);
    rd(ADDR_FAIL_MASK, RST_FAIL_MASK);
    wr(ADDR_STICKY, 8'hFF);
    rd(ADDR_STICKY, 8'h02);
    loop_locked_i <= 1'b0;
    rd(ADDR_STICKY, 8'h02);
    rd(ADDR_STICKY, 8'h00);
    loop_locked_i <= 1'b1;
    rd(8'h50, 8'h00);
    // forced ref1, holdover, freerun, auto; ignored select bits are random
    rnd_r = xorshift(rnd_r);
    mw = '{8'h62, 8'h01 | (rnd_r[7:0] & 8'hC0),
           8'h00 | (rnd_r[15:8] & 8'hC0), 8'h23};
    ms = '{LOOP_LOCKED, LOOP_HOLDOVER, LOOP_FREERUN, LOOP_LOCKED};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MODE_REFSEL, mw[i]);
      repeat (4) @(posedge ref_clk_i);
      probe(1, lp(ms[i], i == 2, mw[i][5]));
      if (i != 2) probe(3, {15'h0000, i < 2});
      if (i == 0) rd(ADDR_MODE_REFSEL, 8'h62);
    end
    rnd_r = xorshift(rnd_r);
    ext_fb_phase_i <= rnd_r[15:0];
    repeat (3) @(posedge ref_clk_i);
    probe(2, rnd_r[15:0]);
    wr(ADDR_MODE_REFSEL, 8'h03);
    repeat (3) @(posedge ref_clk_i);
    probe(2, 16'h0000);
    // forced ref1: guard failure is masked from holdover by default
    wr(ADDR_MODE_REFSEL, 8'h42);
    step(4'h0, 4'h8);
    probe(1, lp(LOOP_LOCKED, 1'b0, 1'b0));
    step(4'h0, 4'h2);
    probe(1, lp(LOOP_HOLDOVER, 1'b0, 1'b0));
    probe(3, 16'h0001);
    rd(ADDR_STICKY, 8'h03);
    rd(ADDR_STICKY, 8'h01);
    // automatic: switch on signal loss, never guard-only holdover mask
    wr(ADDR_MODE_REFSEL, 8'h03);
    wr(ADDR_FAIL_MASK, 8'h17);
    step(4'h1, 4'h0);
    probe(3, 16'h0001);
    rd(ADDR_MODE_REFSEL, 8'h43);
    step(4'h1, 4'h1);
    probe(1, lp(LOOP_HOLDOVER, 1'b0, 1'b0));
    step(4'h0, 4'h1);
    probe(1, lp(LOOP_LOCKED, 1'b0, 1'b0));
    probe(3, 16'h0000);
    step(4'h0, 4'h0);
    wr(ADDR_FAIL_MASK, RST_FAIL_MASK);
    step(4'h1, 4'h0);
    probe(3, 16'h0000);
    step(4'h0, 4'h0);
    // equal priorities: no return after recovery
    ref1_prio_i <= 3'h0;
    wr(ADDR_FAIL_MASK, 8'h17);
    step(4'h1, 4'h0);
    probe(3, 16'h0001);
    step(4'h0, 4'h0);
    probe(3, 16'h0001);
    for (int i = 0; i < 50 && note_q.size() != 0; i++) begin
      @(posedge ref_clk_i);
    end
    if (note_q.size() != 0) err_total++;
    print_verdict();
  end
endmodule : drm_mode_ctrl_test
